//--- logic/s2ck_pkg.sv
// ****************************************************************
// constants for the second port clock generator and pin one mux
// ****************************************************************
package s2ck_pkg;

   // register addresses
   localparam logic [7:0] ADDR_BITDIV_SRC   = 8'h21; // bit divider source select
   localparam logic [7:0] ADDR_BITDIV_RATIO = 8'h22; // bit divider ratio and power
   localparam logic [7:0] ADDR_WORDDIV      = 8'h23; // word divider ratio and power
   localparam logic [7:0] ADDR_CLK_OUT      = 8'h24; // output clock sources
   localparam logic [7:0] ADDR_PIN1         = 8'h3D; // pin one function

   // reset values
   localparam logic [7:0] RST_BITDIV_SRC    = 8'h01;
   localparam logic [7:0] RST_BITDIV_RATIO  = 8'h02;
   localparam logic [7:0] RST_WORDDIV       = 8'h20;
   localparam logic [7:0] RST_CLK_OUT       = 8'h33;
   localparam logic [7:0] RST_PIN1          = 8'h01;

   // writable field masks, reserved bits read as zero
   localparam logic [7:0] MASK_BITDIV_SRC   = 8'h07;
   localparam logic [7:0] MASK_DIV          = 8'hFF;
   localparam logic [7:0] MASK_CLK_OUT      = 8'h77;
   localparam logic [7:0] MASK_PIN1         = 8'h5F;

   // field positions
   localparam int POWER_BIT     = 7;  // divider power bit
   localparam int RATIO_MSB     = 6;  // divider ratio field top
   localparam int BCLKS_LSB     = 4;  // bit clock output select low bit
   localparam int WCLKS_LSB     = 0;  // word clock output select low bit
   localparam int SEL_W         = 3;  // width of clock select fields
   localparam int PIN_LEVEL_BIT = 6;  // pin one static level
   localparam int FUNC_W        = 5;  // width of pin one function

   // divide-by value used for ratio code zero
   localparam logic [7:0] RATIO_ZERO_DIV = 8'h80;

   // bit divider source codes
   localparam logic [2:0] SRC_ONCHIP_DIV = 3'h0;
   localparam logic [2:0] SRC_CONV_MOD   = 3'h1;
   localparam logic [2:0] SRC_MEAS_MOD   = 3'h3;
   localparam logic [2:0] SRC_PORT1_PIN  = 3'h4;
   localparam logic [2:0] SRC_PORT2_PIN  = 3'h6;

   // output clock source codes
   localparam logic [2:0] OUT_PORT1_DIV  = 3'h0;
   localparam logic [2:0] OUT_PORT1_CONV = 3'h1;
   localparam logic [2:0] OUT_PORT2_DIV  = 3'h3;
   localparam logic [2:0] OUT_PORT2_CONV = 3'h4;

   // pin one function codes
   localparam logic [4:0] FN_DISABLED   = 5'h00;
   localparam logic [4:0] FN_INPUT      = 5'h01;
   localparam logic [4:0] FN_LEVEL      = 5'h03;
   localparam logic [4:0] FN_SHARED     = 5'h04;
   localparam logic [4:0] FN_PDM_CLK    = 5'h05;
   localparam logic [4:0] FN_CLKOUT     = 5'h06;
   localparam logic [4:0] FN_IRQ_FIRST  = 5'h07;
   localparam logic [4:0] FN_IRQ_LAST   = 5'h0A;
   localparam logic [4:0] FN_P1_WCLK    = 5'h0C;
   localparam logic [4:0] FN_P1_BCLK    = 5'h0D;
   localparam logic [4:0] FN_P1_DOUT    = 5'h10;
   localparam logic [4:0] FN_P1_WCLK_B  = 5'h11;
   localparam logic [4:0] FN_P2_BCLK    = 5'h12;
   localparam logic [4:0] FN_P2_DOUT    = 5'h15;
   localparam logic [4:0] FN_SEC_WCLK   = 5'h1B;
   localparam logic [4:0] FN_SEC_BCLK   = 5'h1C;
   localparam logic [4:0] FN_SEC_DOUT   = 5'h1D;

   // divider power state, one-hot
   typedef enum logic [1:0] {
      S2CK_DIV_OFF = 2'b01,
      S2CK_DIV_RUN = 2'b10
   } s2ck_div_state_t;

endpackage

//--- logic/s2ck_top.sv
`timescale 1ns/1ps
`default_nettype none

module s2ck_top #(
   parameter int RATIO_W = 7              // width of divider ratio fields
) (
   input  wire logic       clk_i,                      // system clock, 20 MHz
   input  wire logic       reset_i,                    // synchronous reset, active high
   // register port behind the control interface
   input  wire logic [7:0] reg_addr_i,                 // register address
   input  wire logic [7:0] reg_wdata_i,                // write data
   input  wire logic       reg_wr_i,                   // write strobe
   input  wire logic       reg_rd_i,                   // read strobe
   output logic      [7:0] reg_rdata_o,                // read data, one cycle later
   // divider source clocks
   input  wire logic       onchip_divided_clock_i,
   input  wire logic       converter_modulator_clock_i,
   input  wire logic       measurement_modulator_clock_i,
   input  wire logic       port1_bitclock_pin_i,
   input  wire logic       port2_bitclock_pin_i,
   // other clocks offered to the output selects
   input  wire logic       port1_bitdiv_clock_i,       // first port bit divider
   input  wire logic       port1_worddiv_clock_i,      // first port word divider
   input  wire logic       port1_converter_clock_i,    // first port converter clock
   input  wire logic       port2_converter_clock_i,    // second port converter clock
   // generated clocks of the second port
   output logic            port2_bitclock_out_o,
   output logic            port2_wordclock_out_o,
   // internal sources for pin one
   input  wire logic       shared_output_level_i,
   input  wire logic       pdm_clock_i,
   input  wire logic       clock_out_i,
   input  wire logic [3:0] irq_lines_i,                // irq line one in bit 0
   input  wire logic       port1_wordclock_out_i,
   input  wire logic       port1_bitclock_out_i,
   input  wire logic       port1_serial_out_i,
   input  wire logic       port2_serial_out_i,
   input  wire logic       secondary_wordclock_out_i,
   input  wire logic       secondary_bitclock_out_i,
   input  wire logic       secondary_serial_out_i,
   // pin one
   input  wire logic       pin_one_i,                  // pin level seen by input buffer
   output logic            pin_one_o,                  // pin drive level
   output logic            pin_one_oe_o,               // high while driving the pin
   output logic            pin_one_ibuf_en_o,          // input buffer powered
   output logic            pin_one_routed_o            // pin value to the input muxes
);

   // ****************************************************************
   // register file
   // ****************************************************************

   logic [7:0] bitdiv_src_reg,   bitdiv_src_next;    // source select
   logic [7:0] bitdiv_ratio_reg, bitdiv_ratio_next;  // bit divider ratio and power
   logic [7:0] worddiv_reg,      worddiv_next;       // word divider ratio and power
   logic [7:0] clk_out_reg,      clk_out_next;       // output clock sources
   logic [7:0] pin1_reg,         pin1_next;          // pin one function
   logic [7:0] rdata_reg,        rdata_next;         // read data

   // register writes and read data
   always_comb begin
      bitdiv_src_next   = bitdiv_src_reg;
      bitdiv_ratio_next = bitdiv_ratio_reg;
      worddiv_next      = worddiv_reg;
      clk_out_next      = clk_out_reg;
      pin1_next         = pin1_reg;
      rdata_next        = rdata_reg;
      if (reg_wr_i) begin
         case (reg_addr_i)
            s2ck_pkg::ADDR_BITDIV_SRC: begin
               bitdiv_src_next = reg_wdata_i & s2ck_pkg::MASK_BITDIV_SRC;
            end
            s2ck_pkg::ADDR_BITDIV_RATIO: begin
               bitdiv_ratio_next = reg_wdata_i & s2ck_pkg::MASK_DIV;
            end
            s2ck_pkg::ADDR_WORDDIV: begin
               worddiv_next = reg_wdata_i & s2ck_pkg::MASK_DIV;
            end
            s2ck_pkg::ADDR_CLK_OUT: begin
               clk_out_next = reg_wdata_i & s2ck_pkg::MASK_CLK_OUT;
            end
            s2ck_pkg::ADDR_PIN1: begin
               pin1_next = reg_wdata_i & s2ck_pkg::MASK_PIN1;
            end
            default: begin
               // unmapped address, write dropped
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            s2ck_pkg::ADDR_BITDIV_SRC:   rdata_next = bitdiv_src_reg;
            s2ck_pkg::ADDR_BITDIV_RATIO: rdata_next = bitdiv_ratio_reg;
            s2ck_pkg::ADDR_WORDDIV:      rdata_next = worddiv_reg;
            s2ck_pkg::ADDR_CLK_OUT:      rdata_next = clk_out_reg;
            s2ck_pkg::ADDR_PIN1:         rdata_next = pin1_reg;
            default:                     rdata_next = 8'h00; // unmapped reads zero
         endcase
      end
   end

   // register state
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bitdiv_src_reg   <= s2ck_pkg::RST_BITDIV_SRC;
         bitdiv_ratio_reg <= s2ck_pkg::RST_BITDIV_RATIO;
         worddiv_reg      <= s2ck_pkg::RST_WORDDIV;
         clk_out_reg      <= s2ck_pkg::RST_CLK_OUT;
         pin1_reg         <= s2ck_pkg::RST_PIN1;
         rdata_reg        <= 8'h00;
      end else begin
         bitdiv_src_reg   <= bitdiv_src_next;
         bitdiv_ratio_reg <= bitdiv_ratio_next;
         worddiv_reg      <= worddiv_next;
         clk_out_reg      <= clk_out_next;
         pin1_reg         <= pin1_next;
         rdata_reg        <= rdata_next;
      end
   end

   assign reg_rdata_o = rdata_reg;

   // ****************************************************************
   // bit divider source select
   // ****************************************************************

   localparam int SEL_W_M1 = s2ck_pkg::SEL_W - 1; // top index of the select fields

   logic bitdiv_in; // selected bit divider input

   // reserved codes feed a quiet input
   always_comb begin
      case (bitdiv_src_reg[SEL_W_M1:0])
         s2ck_pkg::SRC_ONCHIP_DIV: bitdiv_in = onchip_divided_clock_i;
         s2ck_pkg::SRC_CONV_MOD:   bitdiv_in = converter_modulator_clock_i;
         s2ck_pkg::SRC_MEAS_MOD:   bitdiv_in = measurement_modulator_clock_i;
         s2ck_pkg::SRC_PORT1_PIN:  bitdiv_in = port1_bitclock_pin_i;
         s2ck_pkg::SRC_PORT2_PIN:  bitdiv_in = port2_bitclock_pin_i;
         default:                  bitdiv_in = 1'b0;
      endcase
   end

   // ****************************************************************
   // bit and word dividers
   // ****************************************************************

   logic               div_in    [2];  // divider inputs, word fed by bit
   logic               div_power [2];  // power bits
   logic [RATIO_W-1:0] div_ratio [2];  // ratio fields
   logic               div_out   [2];  // divided clocks

   assign div_in[0]    = bitdiv_in;
   assign div_in[1]    = div_out[0];
   assign div_power[0] = bitdiv_ratio_reg[s2ck_pkg::POWER_BIT];
   assign div_power[1] = worddiv_reg[s2ck_pkg::POWER_BIT];
   assign div_ratio[0] = bitdiv_ratio_reg[RATIO_W-1:0];
   assign div_ratio[1] = worddiv_reg[RATIO_W-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_div
         s2ck_pkg::s2ck_div_state_t state_reg, state_next; // power state
         logic [RATIO_W:0] cnt_reg, cnt_next;               // input edge count
         logic             prev_reg, prev_next;             // last input level
         logic             out_reg, out_next;               // divided output
         logic [RATIO_W:0] divisor;                         // effective divide-by
         logic             rise;                            // input rising edge

         // ratio code zero divides by the top count
         assign divisor = (div_ratio[gi] == '0) ? (RATIO_W+1)'(s2ck_pkg::RATIO_ZERO_DIV)
                                                : {1'b0, div_ratio[gi]};
         assign rise    = div_in[gi] & ~prev_reg;

         // divider next state
         always_comb begin
            state_next = state_reg;
            cnt_next   = cnt_reg;
            prev_next  = div_in[gi];
            out_next   = out_reg;
            case (state_reg)
               s2ck_pkg::S2CK_DIV_OFF: begin
                  // held quiet while unpowered
                  cnt_next = '0;
                  out_next = 1'b0;
                  if (div_power[gi]) begin
                     state_next = s2ck_pkg::S2CK_DIV_RUN;
                  end
               end
               s2ck_pkg::S2CK_DIV_RUN: begin
                  if (!div_power[gi]) begin
                     // power bit cleared, stop at once
                     state_next = s2ck_pkg::S2CK_DIV_OFF;
                     cnt_next   = '0;
                     out_next   = 1'b0;
                  end else if (divisor == {{RATIO_W{1'b0}}, 1'b1}) begin
                     // divide by one passes the input through
                     out_next = div_in[gi];
                  end else if (rise) begin
                     // count input edges, wrap at the divisor
                     if (cnt_reg >= divisor - 1'b1) begin
                        cnt_next = '0;
                     end else begin
                        cnt_next = cnt_reg + 1'b1;
                     end
                     out_next = (cnt_next < (divisor >> 1));
                  end
               end
               default: begin
                  state_next = s2ck_pkg::S2CK_DIV_OFF;
                  cnt_next   = '0;
                  out_next   = 1'b0;
               end
            endcase
         end

         // divider state
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               state_reg <= s2ck_pkg::S2CK_DIV_OFF;
               cnt_reg   <= '0;
               prev_reg  <= 1'b0;
               out_reg   <= 1'b0;
            end else begin
               state_reg <= state_next;
               cnt_reg   <= cnt_next;
               prev_reg  <= prev_next;
               out_reg   <= out_next;
            end
         end

         assign div_out[gi] = out_reg;
      end
   endgenerate

   // ****************************************************************
   // output clock selects
   // ****************************************************************

   logic bclk_out_reg, bclk_out_next; // selected bit clock
   logic wclk_out_reg, wclk_out_next; // selected word clock

   // pick each port clock from its sources
   always_comb begin
      case (clk_out_reg[s2ck_pkg::BCLKS_LSB +: s2ck_pkg::SEL_W])
         s2ck_pkg::OUT_PORT1_DIV:  bclk_out_next = port1_bitdiv_clock_i;
         s2ck_pkg::OUT_PORT1_CONV: bclk_out_next = port1_converter_clock_i;
         s2ck_pkg::OUT_PORT2_DIV:  bclk_out_next = div_out[0];
         s2ck_pkg::OUT_PORT2_CONV: bclk_out_next = port2_converter_clock_i;
         default:                  bclk_out_next = 1'b0;
      endcase
      case (clk_out_reg[s2ck_pkg::WCLKS_LSB +: s2ck_pkg::SEL_W])
         s2ck_pkg::OUT_PORT1_DIV:  wclk_out_next = port1_worddiv_clock_i;
         s2ck_pkg::OUT_PORT1_CONV: wclk_out_next = port1_converter_clock_i;
         s2ck_pkg::OUT_PORT2_DIV:  wclk_out_next = div_out[1];
         s2ck_pkg::OUT_PORT2_CONV: wclk_out_next = port2_converter_clock_i;
         default:                  wclk_out_next = 1'b0;
      endcase
   end

   // output clock flops
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bclk_out_reg <= 1'b0;
         wclk_out_reg <= 1'b0;
      end else begin
         bclk_out_reg <= bclk_out_next;
         wclk_out_reg <= wclk_out_next;
      end
   end

   assign port2_bitclock_out_o  = bclk_out_reg;
   assign port2_wordclock_out_o = wclk_out_reg;

   // ****************************************************************
   // pin one function mux
   // ****************************************************************

   logic [s2ck_pkg::FUNC_W-1:0] pin_func;              // function field
   logic                        pin_level;             // static level bit
   logic                        pin_out_reg, pin_out_next;
   logic                        pin_oe_reg,  pin_oe_next;
   logic                        pin_ibuf_reg, pin_ibuf_next;
   logic                        pin_route_reg, pin_route_next;
   logic [1:0]                  irq_idx;               // irq line index

   assign pin_func  = pin1_reg[s2ck_pkg::FUNC_W-1:0];
   assign pin_level = pin1_reg[s2ck_pkg::PIN_LEVEL_BIT];
   assign irq_idx   = 2'(pin_func - s2ck_pkg::FN_IRQ_FIRST);

   // drive, enable and routing for each function
   always_comb begin
      pin_out_next   = 1'b0;
      pin_oe_next    = 1'b1;
      pin_ibuf_next  = 1'b0;
      pin_route_next = 1'b0;
      case (pin_func)
         s2ck_pkg::FN_DISABLED: begin
            pin_oe_next = 1'b0;
         end
         s2ck_pkg::FN_INPUT: begin
            pin_oe_next    = 1'b0;
            pin_ibuf_next  = 1'b1;
            pin_route_next = pin_one_i;
         end
         s2ck_pkg::FN_LEVEL:    pin_out_next = pin_level;
         s2ck_pkg::FN_SHARED:   pin_out_next = shared_output_level_i;
         s2ck_pkg::FN_PDM_CLK:  pin_out_next = pdm_clock_i;
         s2ck_pkg::FN_CLKOUT:   pin_out_next = clock_out_i;
         s2ck_pkg::FN_P1_WCLK:  pin_out_next = port1_wordclock_out_i;
         s2ck_pkg::FN_P1_BCLK:  pin_out_next = port1_bitclock_out_i;
         s2ck_pkg::FN_P1_DOUT:  pin_out_next = port1_serial_out_i;
         s2ck_pkg::FN_P1_WCLK_B: pin_out_next = port1_wordclock_out_i;
         s2ck_pkg::FN_P2_BCLK:  pin_out_next = bclk_out_reg;
         s2ck_pkg::FN_P2_DOUT:  pin_out_next = port2_serial_out_i;
         s2ck_pkg::FN_SEC_WCLK: pin_out_next = secondary_wordclock_out_i;
         s2ck_pkg::FN_SEC_BCLK: pin_out_next = secondary_bitclock_out_i;
         s2ck_pkg::FN_SEC_DOUT: pin_out_next = secondary_serial_out_i;
         default: begin
            if (pin_func >= s2ck_pkg::FN_IRQ_FIRST && pin_func <= s2ck_pkg::FN_IRQ_LAST) begin
               pin_out_next = irq_lines_i[irq_idx];
            end else begin
               pin_oe_next = 1'b0;
            end
         end
      endcase
   end

   // pin flops
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_out_reg   <= 1'b0;
         pin_oe_reg    <= 1'b0;
         pin_ibuf_reg  <= 1'b0;
         pin_route_reg <= 1'b0;
      end else begin
         pin_out_reg   <= pin_out_next;
         pin_oe_reg    <= pin_oe_next;
         pin_ibuf_reg  <= pin_ibuf_next;
         pin_route_reg <= pin_route_next;
      end
   end

   assign pin_one_o         = pin_out_reg;
   assign pin_one_oe_o      = pin_oe_reg;
   assign pin_one_ibuf_en_o = pin_ibuf_reg;
   assign pin_one_routed_o  = pin_route_reg;

endmodule

`default_nettype wire

//--- tb/s2ck_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// free-running source clocks, bit k has a period of 2^(k+1) clocks
// ****************************************************************
module s2ck_src_model (
   input  wire logic       clk_i,       // system clock
   input  wire logic       reset_i,     // restarts the counter
   output var  logic [6:0] ck_o = 7'h00 // weighted clocks
);
   // binary counter, every bit a slower clock
   always @(posedge clk_i) begin
      ck_o <= reset_i ? 7'h00 : ck_o + 7'h01;
   end
endmodule
`default_nettype wire

//--- tb/s2ck_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pin one and output clock select checks
// ****************************************************************
module s2ck_props (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       pin_one_i,
   input wire logic       shared_output_level_i,
   input wire logic       port1_converter_clock_i,
   input wire logic       port1_worddiv_clock_i,
   input wire logic       port2_bitclock_out_o,
   input wire logic       port2_wordclock_out_o,
   input wire logic       pin_one_o,
   input wire logic       pin_one_oe_o,
   input wire logic       pin_one_ibuf_en_o,
   input wire logic       pin_one_routed_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic       pw; // write to pin one register
   logic       cw; // write to clock output register
   logic [4:0] fn; // function code being written
   assign pw = reg_wr_i && (reg_addr_i == s2ck_pkg::ADDR_PIN1);
   assign cw = reg_wr_i && (reg_addr_i == s2ck_pkg::ADDR_CLK_OUT);
   assign fn = reg_wdata_i[4:0];
   pin_off_a: assert property (
      pw && fn inside {5'h00, 5'h02, 5'h0B} ##1 !reg_wr_i
      |=> !pin_one_oe_o && !pin_one_ibuf_en_o) else $error("pin not off");
   pin_input_a: assert property (
      pw && fn == 5'h01 ##1 !reg_wr_i |=> pin_one_ibuf_en_o && !pin_one_oe_o)
      else $error("pin not input");
   pin_route_a: assert property (
      pin_one_ibuf_en_o |-> pin_one_routed_o == $past(pin_one_i)) else $error("bad route");
   pin_level_a: assert property (
      pw && fn == 5'h03 ##1 !reg_wr_i
      |=> pin_one_oe_o && pin_one_o == $past(reg_wdata_i[6], 2)) else $error("bad level");
   pin_shared_a: assert property (
      pw && fn == 5'h04 ##1 !reg_wr_i
      |=> pin_one_oe_o && pin_one_o == $past(shared_output_level_i)) else $error("bad shared");
   bclk_sel_a: assert property (
      cw && reg_wdata_i[6:4] == 3'h1 ##1 !reg_wr_i
      |=> port2_bitclock_out_o == $past(port1_converter_clock_i)) else $error("bad bclk");
   wclk_sel_a: assert property (
      cw && reg_wdata_i[2:0] == 3'h0 ##1 !reg_wr_i
      |=> port2_wordclock_out_o == $past(port1_worddiv_clock_i)) else $error("bad wclk");
   clk_resv_a: assert property (
      cw && reg_wdata_i[6:4] inside {3'h2, 3'h5, 3'h6, 3'h7} ##1 !reg_wr_i
      |=> !port2_bitclock_out_o) else $error("reserved bclk active");
endmodule
bind s2ck_top s2ck_props u_props (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .pin_one_i, .shared_output_level_i, .port1_converter_clock_i, .port1_worddiv_clock_i,
   .port2_bitclock_out_o, .port2_wordclock_out_o, .pin_one_o, .pin_one_oe_o,
   .pin_one_ibuf_en_o, .pin_one_routed_o);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// bench: registers, pin one functions, clock dividers
// ****************************************************************
module tb;
   logic        clk_i = 1'b0;           // system clock
   logic        reset_i = 1'b1;         // held six clocks
   logic [7:0]  a = 8'h00;              // register address
   logic [7:0]  d = 8'h00;              // write data
   logic        wr = 1'b0;              // write strobe
   logic        rd = 1'b0;              // read strobe
   logic        pin = 1'b0;             // level on pin one
   logic [13:0] src = 14'h0000;         // pin one internal sources
   logic [7:0]  rdat, q;                // read data
   logic [6:0]  ck;                     // source clocks
   logic        bo, wo, po, oe, ib, ro; // design outputs
   int          bad_count = 0;
   int          checked = 0;
   int          p;                      // measured period
   logic [11:0] r;
   logic [7:0]  ad [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h3D, 8'h25}; // last unmapped
   logic [7:0]  rv [6] = '{8'h01, 8'h02, 8'h20, 8'h33, 8'h01, 8'h00}; // reset values
   logic [7:0]  mk [6] = '{8'h07, 8'hFF, 8'hFF, 8'h77, 8'h5F, 8'h00}; // writable bits
   // function, level, oe, ibuf, pin
   logic [11:0] pr [22] = '{12'h000, 12'h012, 12'h020, 12'h03D, 12'h034, 12'h045, 12'h054,
      12'h065, 12'h074, 12'h085, 12'h095, 12'h0A4, 12'h0B0, 12'h0C5, 12'h0D4, 12'h104,
      12'h115, 12'h155, 12'h1B5, 12'h1C4, 12'h1D5, 12'h1F0};
   // source, bit ratio, word ratio, out select, which output, period
   logic [47:0] cr [19] = '{48'h008320330006, 48'h018120330004, 48'h038220330010,
      48'h048120330010, 48'h068120330020, 48'h008020330100, 48'h000320330000,
      48'h028120330000, 48'h008120130010, 48'h008120030080, 48'h008120430008,
      48'h008120230000, 48'h00818533100A, 48'h008180331100, 48'h008105331000,
      48'h008120301040, 48'h008120311010, 48'h008120341008, 48'h008120321000};
   s2ck_src_model u_src (.clk_i(clk_i), .reset_i(reset_i), .ck_o(ck));
   s2ck_top dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(a), .reg_wdata_i(d),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .onchip_divided_clock_i(ck[0]), .converter_modulator_clock_i(ck[1]),
      .measurement_modulator_clock_i(ck[2]), .port1_bitclock_pin_i(ck[3]),
      .port2_bitclock_pin_i(ck[4]), .port1_bitdiv_clock_i(ck[6]),
      .port1_worddiv_clock_i(ck[5]), .port1_converter_clock_i(ck[3]),
      .port2_converter_clock_i(ck[2]), .port2_bitclock_out_o(bo), .port2_wordclock_out_o(wo),
      .shared_output_level_i(src[13]), .pdm_clock_i(src[12]), .clock_out_i(src[11]),
      .irq_lines_i(src[10:7]), .port1_wordclock_out_i(src[6]), .port1_bitclock_out_i(src[5]),
      .port1_serial_out_i(src[4]), .port2_serial_out_i(src[3]),
      .secondary_wordclock_out_i(src[2]), .secondary_bitclock_out_i(src[1]),
      .secondary_serial_out_i(src[0]), .pin_one_i(pin), .pin_one_o(po),
      .pin_one_oe_o(oe), .pin_one_ibuf_en_o(ib), .pin_one_routed_o(ro));
   // clock, 50 ns period
   always #25 clk_i = ~clk_i;
   task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrr(input logic [7:0] av, input logic [7:0] dv);
      @(posedge clk_i);
      a <= av;
      d <= dv;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] av);
      @(posedge clk_i);
      a <= av;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      q = rdat;
   endtask
   // fixed window, period between second and third rise
   task automatic meas(input logic w);
      logic prv;
      logic v;
      int   n;
      int   t0;
      prv = 1'b0;
      n = 0;
      t0 = 0;
      p = 0;
      for (int i = 0; i < 900; i++) begin
         @(negedge clk_i);
         v = w ? wo : bo;
         if (v === 1'b1 && prv !== 1'b1) begin
            n++;
            if (n == 2) t0 = i;
            if (n == 3) p = i - t0;
         end
         prv = v;
      end
   endtask
   task automatic stop_test();
      if (bad_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      foreach (ad[i]) begin
         rdr(ad[i]);
         chk("reset", q, rv[i]);
      end
      chk("ibuf", ib, 1'b1);
      foreach (ad[i]) begin
         wrr(ad[i], 8'hFF);
         rdr(ad[i]);
         chk("mask", q, mk[i]);
      end
      for (int v = 0; v < 2; v++) begin
         foreach (pr[i]) begin
            r = pr[i];
            @(posedge clk_i);
            src <= 14'h2B4D ^ {14{v[0]}};
            pin <= v[0];
            wrr(8'h3D, {1'b0, r[3], 1'b0, r[8:4]});
            @(posedge clk_i);
            @(negedge clk_i);
            chk("oe", oe, r[2]);
            chk("ibuf", ib, r[1]);
            chk("routed", ro, r[1] & v[0]);
            if (r[2]) chk("pin", po, r[0] ^ (v[0] & (r[8:4] != 5'h03)));
         end
      end
      foreach (cr[i]) begin
         wrr(8'h21, cr[i][47:40]);
         wrr(8'h22, cr[i][39:32]);
         wrr(8'h23, cr[i][31:24]);
         wrr(8'h24, cr[i][23:16]);
         meas(cr[i][12]);
         chk("period", p[11:0], cr[i][11:0]);
      end
      // code eighteen follows the selected bit clock, one clock late
      wrr(8'h3D, 8'h12);
      @(posedge clk_i);
      @(negedge clk_i);
      chk("oe", oe, 1'b1);
      q[0] = bo;
      for (int k = 0; k < 3; k++) begin
         @(negedge clk_i);
         chk("p2bclk", po, q[0]);
         q[0] = bo;
      end
      // reset in mid-run returns pin one to input
      wrr(8'h3D, 8'h43);
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      rdr(8'h3D);
      chk("rereset", q, 8'h01);
      chk("oe", oe, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
